// ### port1_strap_asserts.sv
// assertion checker for the port 1 strap default logic
`timescale 1ns/1ps
module port1_strap_asserts
    import port1_strap_pkg::*;
(
    // clock and reset
    input wire logic                    aclk,
    input wire logic                    aresetn,
    // strap pins and loader
    input wire logic                    port1_speed_cfg_input,
    input wire logic                    eeprom_load_valid,
    input wire logic [port1_strap_pkg::STRAP_COUNT-1:0] eeprom_strap_value,
    input wire logic                    eeprom_reload_req,
    // settings out
    input wire logic                    speed_select_low_bit,
    input wire logic                    duplex_mode_bit,
    input wire logic                    advert_10fd,
    input wire logic                    advert_10hd,
    input wire logic [port1_strap_pkg::MODE_W-1:0] phy_mode,
    input wire logic                    port1_backpressure_active,
    input wire logic                    port1_tx_pause_active,
    input wire logic                    port1_rx_pause_active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // loader values reach the settings two edges after the pulse
    chk_speed_load: assert property (eeprom_load_valid |-> ##2
        speed_select_low_bit == $past(eeprom_strap_value[STRAP_SPEED], 2))
        else $error("speed bit not taken from loader");
    chk_duplex_load: assert property (eeprom_load_valid |-> ##2
        duplex_mode_bit == $past(eeprom_strap_value[STRAP_DUPLEX], 2))
        else $error("duplex bit not taken from loader");
    chk_adv_half: assert property (eeprom_load_valid |-> ##2
        advert_10hd == !$past(eeprom_strap_value[STRAP_SPEED], 2))
        else $error("half duplex advert wrong after load");
    chk_adv_full: assert property (eeprom_load_valid |-> ##2
        advert_10fd == (!$past(eeprom_strap_value[STRAP_SPEED], 2)
        && $past(eeprom_strap_value[STRAP_DUPLEX], 2)))
        else $error("full duplex advert wrong after load");
    chk_mode_load: assert property (eeprom_load_valid |-> ##2
        phy_mode == {1'b0, $past(eeprom_strap_value[STRAP_SPEED], 2),
        $past(eeprom_strap_value[STRAP_DUPLEX], 2)})
        else $error("operating mode wrong after load");
    chk_bp_load: assert property (eeprom_load_valid |-> ##2
        port1_backpressure_active ==
        ($past(eeprom_strap_value[STRAP_BACKPRES], 2)
        && !$past(eeprom_strap_value[STRAP_DUPLEX], 2)))
        else $error("backpressure wrong after load");
    chk_pause_load: assert property (eeprom_load_valid |-> ##2
        !port1_tx_pause_active && !port1_rx_pause_active)
        else $error("pause active without manual select");
    chk_capture_pin: assert property (aresetn && !$past(aresetn)
        |-> ##2 speed_select_low_bit == $past(port1_speed_cfg_input, 2))
        else $error("speed pin not captured at release");
    chk_reload_pulse: assert property (eeprom_reload_req |=>
        !eeprom_reload_req)
        else $error("reload request longer than one cycle");
endmodule

bind port1_strap_defaults port1_strap_asserts u_chk (.aclk, .aresetn,
    .port1_speed_cfg_input, .eeprom_load_valid, .eeprom_strap_value,
    .eeprom_reload_req, .speed_select_low_bit, .duplex_mode_bit,
    .advert_10fd, .advert_10hd, .phy_mode, .port1_backpressure_active,
    .port1_tx_pause_active, .port1_rx_pause_active);

// ### port1_strap_defaults.sv
// port 1 strap default logic with axi4-lite register access
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module port1_strap_defaults
    import port1_strap_pkg::*;
(
    // clock and reset
    input  wire logic                          aclk,
    input  wire logic                          aresetn,
    // axi4-lite write address
    input  wire logic [7:0]                    awaddr,
    input  wire logic                          awvalid,
    output logic                               awready,
    // axi4-lite write data
    input  wire logic [31:0]                   wdata,
    input  wire logic [3:0]                    wstrb,
    input  wire logic                          wvalid,
    output logic                               wready,
    // axi4-lite write response
    output logic [1:0]                         bresp,
    output logic                               bvalid,
    input  wire logic                          bready,
    // axi4-lite read address
    input  wire logic [7:0]                    araddr,
    input  wire logic                          arvalid,
    output logic                               arready,
    // axi4-lite read data
    output logic [31:0]                        rdata,
    output logic [1:0]                         rresp,
    output logic                               rvalid,
    input  wire logic                          rready,
    // configuration strap pins
    input  wire logic                          port1_speed_cfg_input,
    input  wire logic                          port1_duplex_cfg_input,
    input  wire logic                          port1_backpressure_cfg_input,
    input  wire logic                          port1_pause_cfg_input,
    // eeprom loader
    input  wire logic                          eeprom_load_valid,
    input  wire logic [port1_strap_pkg::STRAP_COUNT-1:0] eeprom_strap_value,
    output logic                               eeprom_reload_req,
    // phy and flow control settings
    output logic                               speed_select_low_bit,
    output logic                               duplex_mode_bit,
    output logic                               advert_10fd,
    output logic                               advert_10hd,
    output logic [port1_strap_pkg::MODE_W-1:0] phy_mode,
    output logic                               port1_backpressure_active,
    output logic                               port1_tx_pause_active,
    output logic                               port1_rx_pause_active
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic              captured;
        logic              apply;
        logic              reload_req;
        logic [7:0]        awaddr;
        logic              aw_got;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              w_got;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [31:0]       rdata;
        logic              speed;
        logic              duplex;
        logic              adv_10fd;
        logic              adv_10hd;
        logic [MODE_W-1:0] mode;
        logic              bp_en;
        logic              rx_en;
        logic              tx_en;
        logic              manual_fc;
        logic              bp_active;
        logic              tx_active;
        logic              rx_active;
    } state_s;

    localparam state_s STATE_RESET = '{
        speed:     STRAP_UNDRIVEN[STRAP_SPEED],
        duplex:    STRAP_UNDRIVEN[STRAP_DUPLEX],
        bp_en:     STRAP_UNDRIVEN[STRAP_BACKPRES],
        rx_en:     STRAP_UNDRIVEN[STRAP_PAUSE],
        tx_en:     STRAP_UNDRIVEN[STRAP_PAUSE],
        manual_fc: MANUAL_FC_DEFAULT,
        mode:      {MODE_FORCED_TOP, STRAP_UNDRIVEN[STRAP_SPEED],
                    STRAP_UNDRIVEN[STRAP_DUPLEX]},
        default:   '0};

    state_s r_reg;
    state_s r_next;

    logic [STRAP_COUNT-1:0] pin_vec;
    logic [STRAP_COUNT-1:0] latched_vec;
    logic [STRAP_COUNT-1:0] eff_vec;
    logic                   capture;
    logic                   restore;
    logic                   wr_fire;
    logic [7:0]             wr_word;
    logic [7:0]             rd_word;

    ////////////////////////////////////////////////////////////////////////
    // strap cells

    assign pin_vec = {port1_pause_cfg_input, port1_backpressure_cfg_input,
                      port1_duplex_cfg_input, port1_speed_cfg_input};

    // first edge after reset release samples every pin once
    assign capture = ~r_reg.captured;

    genvar gi;
    generate
        for (gi = 0; gi < STRAP_COUNT; gi++) begin : g_cell
            strap_cell #(
                .DEFAULT_VALUE (STRAP_UNDRIVEN[gi])
            ) u_cell (
                .aclk            (aclk),
                .aresetn         (aresetn),
                .capture         (capture),
                .restore         (restore),
                .ee_load         (eeprom_load_valid),
                .pin_value       (pin_vec[gi]),
                .ee_value        (eeprom_strap_value[gi]),
                .latched_value   (latched_vec[gi]),
                .effective_value (eff_vec[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    assign awready = ~r_reg.aw_got;
    assign wready  = ~r_reg.w_got;
    assign arready = ~r_reg.rvalid;
    assign wr_fire = r_reg.aw_got & r_reg.w_got & ~r_reg.bvalid;
    assign wr_word = {r_reg.awaddr[7:2], 2'h0};
    assign rd_word = {araddr[7:2], 2'h0};

    // control register write: digital reset or reload drops overrides
    assign restore = wr_fire & (wr_word == CFG_CONTROL_OFFSET)
                     & r_reg.wstrb[0]
                     & (r_reg.wdata[CTRL_DIGRST_BIT]
                        | r_reg.wdata[CTRL_RELOAD_BIT]);

    // read mux over the current state
    function automatic logic [33:0] read_word(input logic [7:0] a);
        logic [31:0] d;
        logic [1:0]  resp;
        d    = 32'h0;
        resp = RESP_OKAY;
        case (a)
            BASIC_CTRL_OFFSET: begin
                d[BASIC_SPEED_BIT]  = r_reg.speed;
                d[BASIC_DUPLEX_BIT] = r_reg.duplex;
            end
            AN_ADVERT_OFFSET: begin
                d[ADV_10HD_BIT] = r_reg.adv_10hd;
                d[ADV_10FD_BIT] = r_reg.adv_10fd;
            end
            OP_MODES_OFFSET: begin
                d[MODE_LSB +: MODE_W] = r_reg.mode;
            end
            MANUAL_FLOW_OFFSET: begin
                d[FLOW_BP_BIT]     = r_reg.bp_en;
                d[FLOW_RX_BIT]     = r_reg.rx_en;
                d[FLOW_TX_BIT]     = r_reg.tx_en;
                d[FLOW_MANUAL_BIT] = r_reg.manual_fc;
            end
            STRAP_STATUS_OFFSET: begin
                d[STATUS_LATCH_LSB +: STRAP_COUNT] = latched_vec;
                d[STATUS_EFF_LSB +: STRAP_COUNT]   = eff_vec;
                d[STATUS_CAPT_BIT]                 = r_reg.captured;
            end
            CFG_CONTROL_OFFSET: begin
                d = 32'h0;
            end
            default: begin
                resp = RESP_SLVERR;
            end
        endcase
        return {resp, d};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        r_next            = r_reg;
        r_next.captured   = 1'b1;
        r_next.reload_req = restore;
        // defaults reload one cycle after the strap cells settle
        r_next.apply      = capture | restore | eeprom_load_valid;

        // write address and data taken in either order
        if (awvalid && awready) begin
            r_next.aw_got = 1'b1;
            r_next.awaddr = awaddr;
        end
        if (wvalid && wready) begin
            r_next.w_got = 1'b1;
            r_next.wdata = wdata;
            r_next.wstrb = wstrb;
        end
        if (r_reg.bvalid && bready) begin
            r_next.bvalid = 1'b0;
        end

        // register write; software may overwrite the defaults
        if (wr_fire) begin
            r_next.aw_got = 1'b0;
            r_next.w_got  = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp  = RESP_OKAY;
            case (wr_word)
                BASIC_CTRL_OFFSET: begin
                    if (r_reg.wstrb[0]) begin
                        r_next.speed  = r_reg.wdata[BASIC_SPEED_BIT];
                        r_next.duplex = r_reg.wdata[BASIC_DUPLEX_BIT];
                    end
                end
                AN_ADVERT_OFFSET: begin
                    if (r_reg.wstrb[0]) begin
                        r_next.adv_10hd = r_reg.wdata[ADV_10HD_BIT];
                        r_next.adv_10fd = r_reg.wdata[ADV_10FD_BIT];
                    end
                end
                OP_MODES_OFFSET: begin
                    if (r_reg.wstrb[0]) begin
                        r_next.mode = r_reg.wdata[MODE_LSB +: MODE_W];
                    end
                end
                MANUAL_FLOW_OFFSET: begin
                    if (r_reg.wstrb[0]) begin
                        r_next.bp_en     = r_reg.wdata[FLOW_BP_BIT];
                        r_next.rx_en     = r_reg.wdata[FLOW_RX_BIT];
                        r_next.tx_en     = r_reg.wdata[FLOW_TX_BIT];
                        r_next.manual_fc = r_reg.wdata[FLOW_MANUAL_BIT];
                    end
                end
                STRAP_STATUS_OFFSET, CFG_CONTROL_OFFSET: begin
                    r_next.bresp = RESP_OKAY;
                end
                default: begin
                    r_next.bresp = RESP_SLVERR;
                end
            endcase
        end

        // read channel
        if (r_reg.rvalid && rready) begin
            r_next.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            r_next.rvalid              = 1'b1;
            {r_next.rresp, r_next.rdata} = read_word(rd_word);
        end

        // load strap-derived defaults, taking priority over a write
        if (r_reg.apply) begin
            r_next.speed    = eff_vec[STRAP_SPEED];
            r_next.duplex   = eff_vec[STRAP_DUPLEX];
            r_next.adv_10hd = ~eff_vec[STRAP_SPEED];
            r_next.adv_10fd = ~eff_vec[STRAP_SPEED]
                              & eff_vec[STRAP_DUPLEX];
            r_next.mode     = {MODE_FORCED_TOP, eff_vec[STRAP_SPEED],
                               eff_vec[STRAP_DUPLEX]};
            r_next.bp_en    = eff_vec[STRAP_BACKPRES];
            r_next.rx_en    = eff_vec[STRAP_PAUSE];
            r_next.tx_en    = eff_vec[STRAP_PAUSE];
            r_next.manual_fc = MANUAL_FC_DEFAULT;
        end

        // effective flow control toward the datapath
        r_next.bp_active = r_next.bp_en & ~r_next.duplex;
        r_next.tx_active = r_next.manual_fc & r_next.tx_en;
        r_next.rx_active = r_next.manual_fc & r_next.rx_en;
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= STATE_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign bresp                     = r_reg.bresp;
    assign bvalid                    = r_reg.bvalid;
    assign rdata                     = r_reg.rdata;
    assign rresp                     = r_reg.rresp;
    assign rvalid                    = r_reg.rvalid;
    assign eeprom_reload_req         = r_reg.reload_req;
    assign speed_select_low_bit      = r_reg.speed;
    assign duplex_mode_bit           = r_reg.duplex;
    assign advert_10fd               = r_reg.adv_10fd;
    assign advert_10hd               = r_reg.adv_10hd;
    assign phy_mode                  = r_reg.mode;
    assign port1_backpressure_active = r_reg.bp_active;
    assign port1_tx_pause_active     = r_reg.tx_active;
    assign port1_rx_pause_active     = r_reg.rx_active;

endmodule

// ### port1_strap_pkg.sv
// shared constants for the port 1 strap default logic
package port1_strap_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] BASIC_CTRL_OFFSET  = 8'h00;
    localparam logic [7:0] AN_ADVERT_OFFSET   = 8'h04;
    localparam logic [7:0] OP_MODES_OFFSET    = 8'h08;
    localparam logic [7:0] MANUAL_FLOW_OFFSET = 8'h0C;
    localparam logic [7:0] STRAP_STATUS_OFFSET = 8'h10;
    localparam logic [7:0] CFG_CONTROL_OFFSET = 8'h14;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int BASIC_SPEED_BIT  = 0;
    localparam int BASIC_DUPLEX_BIT = 1;
    localparam int ADV_10HD_BIT     = 5;
    localparam int ADV_10FD_BIT     = 6;
    localparam int MODE_LSB         = 0;
    localparam int MODE_W           = 3;
    localparam int FLOW_BP_BIT      = 0;
    localparam int FLOW_RX_BIT      = 1;
    localparam int FLOW_TX_BIT      = 2;
    localparam int FLOW_MANUAL_BIT  = 3;
    localparam int STATUS_LATCH_LSB = 0;
    localparam int STATUS_EFF_LSB   = 4;
    localparam int STATUS_CAPT_BIT  = 8;
    localparam int CTRL_DIGRST_BIT  = 0;
    localparam int CTRL_RELOAD_BIT  = 1;

    ////////////////////////////////////////////////////////////////////////
    // strap slots and reset values
    localparam int STRAP_SPEED    = 0;
    localparam int STRAP_DUPLEX   = 1;
    localparam int STRAP_BACKPRES = 2;
    localparam int STRAP_PAUSE    = 3;
    localparam int STRAP_COUNT    = 4;
    localparam logic [STRAP_COUNT-1:0] STRAP_UNDRIVEN = 4'hF;
    localparam logic MANUAL_FC_DEFAULT = 1'b0;
    localparam logic MODE_FORCED_TOP   = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // bus response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### strap_cell.sv
// one strap bit: latched pin value, loader override and effective value
`timescale 1ns/1ps
module strap_cell #(
    parameter logic DEFAULT_VALUE = 1'b1
) (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // control pulses
    input  wire logic capture,
    input  wire logic restore,
    input  wire logic ee_load,
    // values in
    input  wire logic pin_value,
    input  wire logic ee_value,
    // values out
    output logic      latched_value,
    output logic      effective_value
);

    typedef struct packed {
        logic latched;
        logic ee_val;
        logic overridden;
        logic eff;
    } cell_s;

    localparam cell_s CELL_RESET = '{latched: DEFAULT_VALUE,
                                     ee_val: DEFAULT_VALUE,
                                     overridden: 1'b0,
                                     eff: DEFAULT_VALUE};

    cell_s cell_reg;
    cell_s cell_next;

    // next state: pins only sampled on capture, loader value wins
    always_comb begin
        cell_next = cell_reg;
        if (capture) begin
            cell_next.latched = pin_value;
        end
        if (restore) begin
            cell_next.overridden = 1'b0;
        end
        if (ee_load) begin
            cell_next.overridden = 1'b1;
            cell_next.ee_val     = ee_value;
        end
        cell_next.eff = cell_next.overridden ? cell_next.ee_val
                                             : cell_next.latched;
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cell_reg <= CELL_RESET;
        end else begin
            cell_reg <= cell_next;
        end
    end

    assign latched_value   = cell_reg.latched;
    assign effective_value = cell_reg.eff;

endmodule

// ### strap_source_model.sv
// model of the pulled-up strap pins and of the eeprom loader
`timescale 1ns/1ps
module strap_source_model (
    // clock
    input  wire logic       aclk,
    // bench control
    input  wire logic [3:0] drive_en,
    input  wire logic [3:0] pin_level,
    input  wire logic       load_go,
    input  wire logic [3:0] load_val,
    // strap pins
    output logic            port1_speed_cfg_input,
    output logic            port1_duplex_cfg_input,
    output logic            port1_backpressure_cfg_input,
    output logic            port1_pause_cfg_input,
    // loader
    output logic            eeprom_load_valid,
    output logic [3:0]      eeprom_strap_value
);
    logic [3:0] pins;

    // an undriven pin floats high through its pull-up
    assign pins = (drive_en & pin_level) | ~drive_en;
    assign port1_speed_cfg_input = pins[0];
    assign port1_duplex_cfg_input = pins[1];
    assign port1_backpressure_cfg_input = pins[2];
    assign port1_pause_cfg_input = pins[3];

    // one-cycle load pulse; value scrambled outside the pulse
    initial eeprom_strap_value = 4'h0;
    always @(posedge aclk) begin
        eeprom_load_valid <= load_go;
        eeprom_strap_value <= load_go ? load_val : ~eeprom_strap_value;
    end
endmodule

// ### test_port1_strap_defaults.sv
// self-checking bench for the port 1 strap default logic
`timescale 1ns/1ps
module test_port1_strap_defaults;
    import port1_strap_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [3:0]  drive_en = 4'h0;
    logic [3:0]  pin_level = 4'h0;
    logic        load_go = 1'b0;
    logic [3:0]  load_val = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r;
    logic [31:0] rdata;
    logic        port1_speed_cfg_input, port1_duplex_cfg_input;
    logic        port1_backpressure_cfg_input, port1_pause_cfg_input;
    logic        eeprom_load_valid, eeprom_reload_req;
    logic [3:0]  eeprom_strap_value;
    logic        speed_select_low_bit, duplex_mode_bit;
    logic        advert_10fd, advert_10hd;
    logic [2:0]  phy_mode;
    logic        port1_backpressure_active;
    logic        port1_tx_pause_active, port1_rx_pause_active;
    int          fails = 0;
    int          checks = 0;
    int          cycles = 0;
    int          pulses = 0;

    always #5 aclk = ~aclk;

    port1_strap_defaults DUT (.*);
    strap_source_model u_straps (.*);

    ////////////////////////////////////////////////////////////////////////
    // cycle ceiling and reload pulse counter
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (eeprom_reload_req === 1'b1) pulses <= pulses + 1;
        if (cycles == 3000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite master: hold each channel until its own handshake
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        bit done = 0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                done = 1;
                r = bresp;
                bready <= 1'b0;
            end
        end
    endtask

    task automatic rd_check(input string what, input logic [7:0] a,
                            input logic [31:0] exp);
        bit done = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                done = 1;
                r = rresp;
                rready <= 1'b0;
                check(what, exp, rdata);
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // reset with pins set, loader pulse, and the full default check
    task automatic do_reset(input logic [3:0] en, input logic [3:0] lvl);
        @(posedge aclk);
        aresetn <= 1'b0;
        drive_en <= en;
        pin_level <= lvl;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
    endtask

    task automatic load(input logic [3:0] v);
        @(posedge aclk);
        load_go <= 1'b1;
        load_val <= v;
        @(posedge aclk);
        load_go <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    task automatic check_all(input logic [3:0] s);
        check("outputs", {22'h0, speed_select_low_bit, duplex_mode_bit,
            advert_10fd, advert_10hd, phy_mode, port1_backpressure_active,
            port1_tx_pause_active, port1_rx_pause_active}, {22'h0, s[0],
            s[1], ~s[0] & s[1], ~s[0], 1'b0, s[0], s[1], s[2] & ~s[1],
            2'b00});
        rd_check("basic", BASIC_CTRL_OFFSET, {30'h0, s[1], s[0]});
        rd_check("advert", AN_ADVERT_OFFSET, {25'h0, ~s[0] & s[1], ~s[0],
            5'h0});
        rd_check("modes", OP_MODES_OFFSET, {29'h0, 1'b0, s[0], s[1]});
        rd_check("flow", MANUAL_FLOW_OFFSET, {28'h0, 1'b0, s[3], s[3], s[2]});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        do_reset(4'h0, 4'h0);
        check_all(4'hF);
        rd_check("status", STRAP_STATUS_OFFSET, 32'h1FF);
        $display("test undriven done");
        for (int i = 0; i < 16; i++) begin
            do_reset(4'hF, i[3:0]);
            check_all(i[3:0]);
        end
        $display("test strap table done");
        do_reset(4'hF, 4'h5);
        load(4'hA);
        check_all(4'hA);
        rd_check("status", STRAP_STATUS_OFFSET, 32'h1A5);
        pin_level <= 4'h3;
        axi_write(CFG_CONTROL_OFFSET, 32'h1);
        repeat (3) @(posedge aclk);
        check("reload pulses", 32'h1, pulses);
        check_all(4'h5);
        load(4'hA);
        axi_write(CFG_CONTROL_OFFSET, 32'h2);
        repeat (3) @(posedge aclk);
        check("reload pulses", 32'h2, pulses);
        check_all(4'h5);
        $display("test restore done");
        axi_write(BASIC_CTRL_OFFSET, 32'h0);
        rd_check("basic", BASIC_CTRL_OFFSET, 32'h0);
        axi_write(OP_MODES_OFFSET, 32'h5);
        rd_check("modes", OP_MODES_OFFSET, 32'h5);
        check("mode out", 32'h5, {29'h0, phy_mode});
        axi_write(AN_ADVERT_OFFSET, 32'h60);
        rd_check("advert", AN_ADVERT_OFFSET, 32'h60);
        rd_check("status", STRAP_STATUS_OFFSET, 32'h155);
        axi_write(MANUAL_FLOW_OFFSET, 32'hF);
        repeat (2) @(posedge aclk);
        check("pause", 32'h3, {30'h0, port1_tx_pause_active,
              port1_rx_pause_active});
        axi_write(MANUAL_FLOW_OFFSET, 32'h6);
        repeat (2) @(posedge aclk);
        check("pause", 32'h0, {30'h0, port1_tx_pause_active,
              port1_rx_pause_active});
        $display("test manual flow done");
        axi_write(8'h18, 32'h1);
        check("bresp", RESP_SLVERR, r);
        rd_check("unmapped", 8'h18, 32'h0);
        check("rresp", RESP_SLVERR, r);
        axi_write(STRAP_STATUS_OFFSET, 32'h0);
        check("bresp", RESP_OKAY, r);
        rd_check("status", STRAP_STATUS_OFFSET, 32'h155);
        $display("test bus errors done");
        end_of_test();
    end
endmodule
